// ===== design/fer_pkg.sv
// Package for the 100 Mbit/s receive coding sublayer: codes, register map, timing.
// Assumes a single 20 MHz clock domain and a 32-bit AXI4-Lite register bus.
package fer_pkg;
    // Code-groups, first received bit in bit 4
    localparam logic [4:0] CODE_J = 5'h18;
    localparam logic [4:0] CODE_K = 5'h11;
    localparam logic [4:0] CODE_T = 5'h0d;
    localparam logic [4:0] CODE_IDLE = 5'h1f;
    localparam logic [4:0] CODE_HALT = 5'h04;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_BAD_SSD = 4'he;
    localparam int HUNT_BITS = 10;
    localparam int SD_ONES_RUN = 65;
    localparam int FAULT_ONES = 84;
    localparam int FAULT_DETECT_COUNT = 3;
    // Timing
    localparam int CLOCK_KHZ = 20000;
    localparam int LINK_READY_US = 500;
    localparam int LINK_READY_CYCLES = (LINK_READY_US * CLOCK_KHZ) / 1000;
    // Registers
    localparam logic [31:0] ADDR_CONTROL = 32'h00000000;
    localparam logic [31:0] ADDR_STATUS = 32'h00000004;
    localparam int CTL_FIBER_MODE = 0;
    localparam int CTL_AUTONEG_EN = 1;
    localparam int CTL_SWITCH_MODE = 2;
    localparam int CTL_FAR_END_FAULT_INDICATION_EN = 3;
    localparam int CTL_AUTO_SD_DIS_N = 4;
    localparam logic [4:0] CTL_RESET = 5'h06;
    localparam int STS_LINK100 = 0;
    localparam int STS_LINK = 2;
    localparam int STS_REMOTE_FAULT = 4;
    localparam int STS_RX_ACTIVE = 5;
    localparam int STS_LINK_STATE = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_CARRIER = 3'b001,
        RX_PREAMBLE = 3'b010,
        RX_DATA = 3'b011,
        RX_BAD = 3'b100,
        RX_END = 3'b101
    } fer_rx_state_t;

    typedef enum logic [1:0] {
        LNK_DOWN = 2'b00,
        LNK_WAIT = 2'b01,
        LNK_READY = 2'b10,
        LNK_UP = 2'b11
    } fer_link_state_t;

    typedef struct packed {
        logic valid;
        logic error;
        logic strobe;
        logic [3:0] data;
    } fer_mii_rx_t;
endpackage

// ===== design/fer_rx_pcs_decoder.sv
// Receive coding sublayer: alignment, 5B/4B decoding, carrier sense, link
// monitor, far-end fault send and detect, with an AXI4-Lite register slave.
// Assumes one descrambled serial bit per clock on rxBit, unaligned.
`timescale 1ns/100ps

module fer_rx_pcs_decoder #(
    parameter int LinkReadyCycles = fer_pkg::LINK_READY_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxBit,
    input wire logic fiberSignalDetect,
    input wire logic fiberSelectStrap,
    input wire logic descramblerLocked,
    input wire logic autoNegLinkEnable,
    input wire logic link10Status,
    input wire logic txActive,
    output fer_pkg::fer_mii_rx_t miiRx,
    output logic carrierSense,
    output logic linkUp,
    output logic linkActivityPin,
    output logic txAllowed,
    output logic faultIdleActive,
    output logic faultIdleBit
);
    import fer_pkg::*;

    function automatic logic [4:0] decode5b(input logic [4:0] code);
        logic [4:0] r;
        r = 5'h00;
        case (code)
            5'h1e: r = 5'h10;
            5'h09: r = 5'h11;
            5'h14: r = 5'h12;
            5'h15: r = 5'h13;
            5'h0a: r = 5'h14;
            5'h0b: r = 5'h15;
            5'h0e: r = 5'h16;
            5'h0f: r = 5'h17;
            5'h12: r = 5'h18;
            5'h13: r = 5'h19;
            5'h16: r = 5'h1a;
            5'h17: r = 5'h1b;
            5'h1a: r = 5'h1c;
            5'h1b: r = 5'h1d;
            5'h1c: r = 5'h1e;
            5'h1d: r = 5'h1f;
            default: r = 5'h00;
        endcase
        return r;
    endfunction

    // Two zeros at least two positions apart anywhere in the window
    function automatic logic twoSplitZeros(input logic [9:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            for (int j = i + 2; j < 10; j++) begin
                if (!w[i] && !w[j]) begin
                    hit = 1'b1;
                end
            end
        end
        return hit;
    endfunction

    // Pin synchronisers
    logic [1:0] rxSync_q, sdSync_q, strapSync_q;
    logic rxS, extSdS, strapS;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxSync_q <= 2'h3;
            sdSync_q <= 2'h0;
            strapSync_q <= 2'h0;
        end else begin
            rxSync_q <= {rxSync_q[0], rxBit};
            sdSync_q <= {sdSync_q[0], fiberSignalDetect};
            strapSync_q <= {strapSync_q[0], fiberSelectStrap};
        end
    end
    assign rxS = rxSync_q[1];
    assign extSdS = sdSync_q[1];
    assign strapS = strapSync_q[1];

    // Bit window, newest bit in bit 0
    logic [9:0] win_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            win_q <= 10'h3ff;
        end else begin
            win_q <= {win_q[8:0], rxS};
        end
    end

    logic [4:0] ctrl_q;
    logic fiberMode, autoNegOn, switchMode, fefiEn, autoSdDisN;
    assign fiberMode = ctrl_q[CTL_FIBER_MODE];
    assign autoNegOn = ctrl_q[CTL_AUTONEG_EN];
    assign switchMode = ctrl_q[CTL_SWITCH_MODE];
    assign fefiEn = ctrl_q[CTL_FAR_END_FAULT_INDICATION_EN];
    assign autoSdDisN = ctrl_q[CTL_AUTO_SD_DIS_N];

    wire jkHit = (win_q == {CODE_J, CODE_K});
    wire idlePair = (win_q == {CODE_IDLE, CODE_IDLE});
    wire carrierHit = twoSplitZeros(win_q);
    wire noEnergy = (win_q == 10'h000);

    // Internal signal detect from a run of ones, held until the line goes dead
    logic [6:0] onesRun_q;
    logic intSd_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            onesRun_q <= 7'h00;
            intSd_q <= 1'b0;
        end else begin
            onesRun_q <= !rxS ? 7'h00 : (onesRun_q == 7'h7f ? onesRun_q : onesRun_q + 7'h01);
            if (onesRun_q >= 7'(SD_ONES_RUN)) begin
                intSd_q <= 1'b1;
            end else if (noEnergy) begin
                intSd_q <= 1'b0;
            end
        end
    end
    wire useIntSd = fiberMode && !autoSdDisN;
    wire signalDetect = useIntSd ? intSd_q : extSdS;

    // Far-end fault pattern detector: zero after exactly 84 ones counts one pattern
    logic [1:0] faultPat_q;
    wire farEndFault = (faultPat_q == 2'(FAULT_DETECT_COUNT));
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            faultPat_q <= 2'h0;
        end else if (!rxS) begin
            if (onesRun_q == 7'(FAULT_ONES)) begin
                faultPat_q <= farEndFault ? faultPat_q : faultPat_q + 2'h1;
            end else begin
                faultPat_q <= 2'h0;
            end
        end
    end

    // Link monitor
    fer_link_state_t link_q, link_d;
    logic [15:0] linkCnt_q;
    wire linkTimeout = (linkCnt_q >= 16'(LinkReadyCycles - 1));
    always_comb begin
        link_d = link_q;
        case (link_q)
            LNK_DOWN: link_d = signalDetect ? LNK_WAIT : LNK_DOWN;
            LNK_WAIT: link_d = linkTimeout ? LNK_READY : LNK_WAIT;
            LNK_READY: link_d = (!autoNegOn || autoNegLinkEnable) ? LNK_UP : LNK_READY;
            LNK_UP: link_d = LNK_UP;
            default: link_d = LNK_DOWN;
        endcase
        if (!signalDetect) begin
            link_d = LNK_DOWN;
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            link_q <= LNK_DOWN;
            linkCnt_q <= 16'h0000;
        end else begin
            link_q <= link_d;
            linkCnt_q <= (link_q == LNK_WAIT && link_d == LNK_WAIT) ? linkCnt_q + 16'h0001 : 16'h0000;
        end
    end
    assign linkUp = (link_q == LNK_UP);
    // Transmit and receive both stop on link loss or a reported far-end fault
    assign txAllowed = linkUp && !farEndFault && !faultIdleActive;
    wire rxEnable = linkUp && signalDetect && descramblerLocked && !farEndFault;
    wire linkStatus = linkUp || link10Status;

    // Fault idle transmit
    logic goodLink_q, faultTx_q;
    logic [6:0] faultCnt_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            goodLink_q <= 1'b0;
            faultTx_q <= 1'b0;
            faultCnt_q <= 7'h00;
        end else begin
            goodLink_q <= linkUp ? 1'b1 : (faultTx_q ? 1'b0 : goodLink_q);
            if (linkUp) begin
                faultTx_q <= 1'b0;
            end else if (fefiEn && fiberMode && goodLink_q && !signalDetect) begin
                faultTx_q <= 1'b1;
            end
            faultCnt_q <= (!faultTx_q || faultCnt_q == 7'(FAULT_ONES)) ? 7'h00 : faultCnt_q + 7'h01;
        end
    end
    assign faultIdleActive = faultTx_q;
    assign faultIdleBit = !(faultTx_q && faultCnt_q == 7'(FAULT_ONES));

    // Receive sequencing
    fer_rx_state_t rx_q, rx_d;
    logic [2:0] bitCnt_q;
    logic [3:0] hunt_q;
    fer_mii_rx_t mii_q, mii_d;
    wire symTick = (bitCnt_q == 3'h4);
    wire [4:0] sym = win_q[4:0];
    wire [4:0] dec = decode5b(sym);
    always_comb begin
        rx_d = rx_q;
        mii_d = mii_q;
        mii_d.strobe = 1'b0;
        case (rx_q)
            RX_IDLE: begin
                mii_d = '0;
                if (rxEnable && carrierHit) begin
                    rx_d = RX_CARRIER;
                end
            end
            RX_CARRIER: begin
                if (jkHit) begin
                    rx_d = RX_PREAMBLE;
                    mii_d.valid = 1'b1;
                    mii_d.strobe = 1'b1;
                    mii_d.data = NIB_PREAMBLE;
                end else if (hunt_q == 4'(HUNT_BITS)) begin
                    rx_d = RX_BAD;
                end
            end
            RX_PREAMBLE: begin
                rx_d = RX_DATA;
                mii_d.strobe = 1'b1;
                mii_d.data = NIB_PREAMBLE;
            end
            RX_DATA: begin
                if (symTick) begin
                    if (sym == CODE_T) begin
                        rx_d = RX_END;
                        mii_d = '0;
                    end else begin
                        // Idle, halt and violation codes are strobed as a nibble with data 0 and error set
                        mii_d.strobe = 1'b1;
                        mii_d.data = dec[3:0];
                        mii_d.error = !dec[4];
                    end
                end
            end
            RX_BAD: begin
                mii_d.error = 1'b1;
                mii_d.data = NIB_BAD_SSD;
                mii_d.strobe = symTick;
                if (idlePair) begin
                    rx_d = RX_IDLE;
                    mii_d = '0;
                end
            end
            RX_END: begin
                if (idlePair) begin
                    rx_d = RX_IDLE;
                end
            end
            default: rx_d = RX_IDLE;
        endcase
        if (!rxEnable && rx_q != RX_IDLE) begin
            rx_d = RX_IDLE;
            mii_d = '0;
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_q <= RX_IDLE;
            mii_q <= '0;
            bitCnt_q <= 3'h0;
            hunt_q <= 4'h0;
        end else begin
            rx_q <= rx_d;
            mii_q <= mii_d;
            bitCnt_q <= (jkHit && rx_q == RX_CARRIER) || symTick ? 3'h0 : bitCnt_q + 3'h1;
            hunt_q <= (rx_q == RX_CARRIER) ? hunt_q + 4'h1 : 4'h0;
        end
    end
    assign miiRx = mii_q;
    // Receive states cover the whole valid span, so carrier encloses it
    assign carrierSense = (rx_q != RX_IDLE) || (switchMode && txActive && txAllowed);

    logic linkPin_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            linkPin_q <= 1'b0;
        end else begin
            linkPin_q <= linkStatus;
        end
    end
    assign linkActivityPin = linkPin_q;

    // Register slave: both write channels taken together, one answer outstanding
    logic bvalid_q, rvalid_q, faultSticky_q, strapDone_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    wire wrFire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    wire rdFire = s_axi_arvalid && !rvalid_q;
    wire wrCtrl = wrFire && (s_axi_awaddr == ADDR_CONTROL);
    wire wrOk = (s_axi_awaddr == ADDR_CONTROL) || (s_axi_awaddr == ADDR_STATUS);
    wire rdStatus = rdFire && (s_axi_araddr == ADDR_STATUS);
    wire rdOk = (s_axi_araddr == ADDR_CONTROL) || (s_axi_araddr == ADDR_STATUS);
    wire [31:0] statusWord = {24'h0, link_q, rx_q != RX_IDLE, faultSticky_q, 1'b0,
        linkStatus, 1'b0, linkUp};
    wire [31:0] readWord = (s_axi_araddr == ADDR_CONTROL) ? {27'h0, ctrl_q} :
        (s_axi_araddr == ADDR_STATUS) ? statusWord : 32'h0;
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign s_axi_arready = rdFire;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
        end else begin
            if (wrFire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (rdFire) begin
                rvalid_q <= 1'b1;
                rresp_q <= rdOk ? RESP_OKAY : RESP_SLVERR;
                rdata_q <= readWord;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Strap is caught once, after it has passed the synchroniser
    logic [1:0] strapWait_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTL_RESET;
            strapWait_q <= 2'h0;
            strapDone_q <= 1'b0;
            faultSticky_q <= 1'b0;
        end else begin
            strapWait_q <= (strapWait_q == 2'h3) ? strapWait_q : strapWait_q + 2'h1;
            if (wrCtrl && s_axi_wstrb[0]) begin
                ctrl_q <= s_axi_wdata[4:0];
            end else if (!strapDone_q && strapWait_q == 2'h3) begin
                ctrl_q[CTL_FAR_END_FAULT_INDICATION_EN] <= strapS;
                ctrl_q[CTL_FIBER_MODE] <= strapS;
            end
            strapDone_q <= strapDone_q || (strapWait_q == 2'h3);
            // A new detection in the read cycle wins over the clear
            if (farEndFault) begin
                faultSticky_q <= 1'b1;
            end else if (rdStatus) begin
                faultSticky_q <= 1'b0;
            end
        end
    end
endmodule

// ===== tb/fer_rx_pcs_decoder_sva.sv
// Port checker for the receive coding sublayer.
// Assumes one clock domain; bound onto every fer_rx_pcs_decoder instance.
`timescale 1ns/100ps
module fer_rx_pcs_sva #(
    parameter int LinkReadyCycles = 20
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input fer_pkg::fer_mii_rx_t miiRx,
    input wire logic carrierSense,
    input wire logic linkUp,
    input wire logic link10Status,
    input wire logic linkActivityPin,
    input wire logic txAllowed,
    input wire logic faultIdleActive,
    input wire logic faultIdleBit
);
    import fer_pkg::*;
    logic [7:0] onesRun_q;
    logic zeroSeen_q;
    // Run length is only judged between two zeros, so the first pattern may start anywhere
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            onesRun_q <= 8'h00;
            zeroSeen_q <= 1'b0;
        end else begin
            onesRun_q <= faultIdleBit ? onesRun_q + 8'h01 : 8'h00;
            zeroSeen_q <= faultIdleActive & (zeroSeen_q | !faultIdleBit);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_VALID_START: assert property ($rose(miiRx.valid) |->
        miiRx.strobe && miiRx.data == NIB_PREAMBLE) else $error("packet start not preamble");
    AST_SECOND_PREAMBLE: assert property ($rose(miiRx.valid) |=>
        miiRx.valid && miiRx.strobe && miiRx.data == NIB_PREAMBLE) else $error("no second preamble");
    AST_CRS_COVERS_VALID: assert property (miiRx.valid |-> carrierSense)
        else $error("receive valid outside carrier");
    AST_LINK_LOSS_STOPS_RX: assert property ($fell(linkUp) |-> ##[1:2] !miiRx.valid)
        else $error("receive valid kept after link loss");
    AST_LINK_PIN: assert property (linkActivityPin == $past(linkUp | link10Status))
        else $error("link activity pin wrong");
    AST_TX_NEEDS_LINK: assert property (txAllowed |-> linkUp && !faultIdleActive)
        else $error("transmit allowed without link");
    AST_FAULT_BIT: assert property (!faultIdleBit |-> faultIdleActive)
        else $error("idle zero outside fault signalling");
    AST_FAULT_RUN: assert property (zeroSeen_q && !faultIdleBit |-> onesRun_q == FAULT_ONES)
        else $error("fault idle run length wrong");
    AST_BUS_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write response missing");
endmodule
bind fer_rx_pcs_decoder fer_rx_pcs_sva #(.LinkReadyCycles(LinkReadyCycles)) fer_rx_pcs_sva_inst (
    .clock, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .miiRx, .carrierSense, .linkUp, .link10Status, .linkActivityPin,
    .txAllowed, .faultIdleActive, .faultIdleBit
);

// ===== tb/fer_mac_model.sv
// Behavioural MAC at the far side of the internal MII.
// Assumes startTx is a one-clock pulse from the bench; counts nibbles taken in packets.
`timescale 1ns/100ps
module fer_mac_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic startTx,
    input fer_pkg::fer_mii_rx_t miiRx,
    output logic txActive,
    output int nibbleCount
);
    import fer_pkg::*;
    logic [3:0] txLeft_q;
    // A short burst is enough to judge carrier sense in both modes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            txLeft_q <= 4'h0;
            nibbleCount <= 0;
        end else begin
            if (startTx) begin
                txLeft_q <= 4'hc;
            end else if (txLeft_q != 4'h0) begin
                txLeft_q <= txLeft_q - 4'h1;
            end
            if (miiRx.valid && miiRx.strobe) begin
                nibbleCount <= nibbleCount + 1;
            end
        end
    end
    assign txActive = txLeft_q != 4'h0;
endmodule

// ===== tb/fer_rx_pcs_decoder_bench.sv
// Self-checking bench: register bus, serial receive stream and MAC model.
// Assumes fer_pkg and the design are compiled first; one 20 MHz clock.
`timescale 1ns/100ps
module fer_rx_pcs_decoder_bench;
    import fer_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic rxBit = 1'b1, sigDet = 1'b1, anEn = 1'b0, link10 = 1'b0, startTx = 1'b0, descLock = 1'b1;
    fer_mii_rx_t miiRx;
    logic carrierSense, linkUp, linkPin, txAllowed, faultIdleActive, faultIdleBit, txActive;
    int nibbleCount, mismatches = 0, samples_checked = 0, badSeen = 0, seed = 95798;
    logic [4:0] nibQ[$];
    logic [65:0] busQ[$];
    logic [4:0] codeOf[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic [4:0] errCodes[3] = '{5'h00, 5'h19, CODE_HALT};

    fer_rx_pcs_decoder #(.LinkReadyCycles(20)) fer_rx_pcs_decoder_inst (
        .clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rxBit(rxBit), .fiberSignalDetect(sigDet), .fiberSelectStrap(1'b1),
        .descramblerLocked(descLock), .autoNegLinkEnable(anEn), .link10Status(link10),
        .txActive(txActive), .miiRx(miiRx), .carrierSense(carrierSense), .linkUp(linkUp),
        .linkActivityPin(linkPin), .txAllowed(txAllowed), .faultIdleActive(faultIdleActive),
        .faultIdleBit(faultIdleBit));
    fer_mac_model fer_mac_model_inst (.clock(clock), .reset_n(reset_n), .startTx(startTx),
        .miiRx(miiRx), .txActive(txActive), .nibbleCount(nibbleCount));

    initial forever #25 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic sendBits(input logic [4:0] code, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clock);
            rxBit <= code[i];
        end
    endtask
    task automatic sendOnes(input int n);
        repeat (n) begin
            @(posedge clock);
            rxBit <= 1'b1;
        end
    endtask
    task automatic busWrite(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clock); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        while (!bvalid) @(posedge clock);
        bready <= 1'b0;
    endtask
    task automatic busRead(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] r);
        busQ.push_back({m, e, r});
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge clock);
        rready <= 1'b0;
    endtask
    // Random idle lead shifts the delimiter off any fixed 5-bit boundary
    task automatic sendFrame(input int n, input bit bad);
        logic [3:0] nib;
        sendOnes(30 + ($unsigned($random(seed)) % 10));
        nibQ.push_back({1'b0, NIB_PREAMBLE});
        nibQ.push_back({1'b0, NIB_PREAMBLE});
        sendBits(CODE_J, 5);
        sendBits(CODE_K, 5);
        for (int i = 0; i < n; i++) begin
            nib = 4'($random(seed));
            nibQ.push_back({1'b0, nib});
            sendBits(codeOf[nib], 5);
        end
        if (bad) begin
            foreach (errCodes[i]) begin
                nibQ.push_back(5'h10);
                sendBits(errCodes[i], 5);
            end
        end
        sendBits(CODE_T, 5);
        sendBits(5'h07, 5);
        sendOnes(40);
        check(32'(miiRx.valid), 32'h0);
        check(32'(carrierSense), 32'h0);
        check(32'(nibQ.size()), 32'h0);
    endtask

    always @(posedge clock) begin
        if (rvalid && rready) begin
            check(32'(rresp), 32'(busQ[0][1:0]));
            check(rdata & busQ[0][65:34], busQ[0][33:2]);
            void'(busQ.pop_front());
        end
        if (miiRx.strobe && miiRx.valid) begin
            check(32'({miiRx.error, miiRx.data & {4{!nibQ[0][4]}}}), 32'(nibQ[0]));
            void'(nibQ.pop_front());
        end else if (miiRx.strobe && miiRx.error) begin
            check(32'(miiRx.data), 32'(NIB_BAD_SSD));
            badSeen++;
        end
    end

    initial begin
        #2000000;
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        repeat (6) @(posedge clock);
        busRead(ADDR_CONTROL, 32'h1f, 32'h0f, RESP_OKAY);
        busRead(32'h8, 32'hffffffff, 32'h0, RESP_SLVERR);
        repeat (120) @(posedge clock);
        check(32'(linkUp), 32'h0);
        busRead(ADDR_STATUS, 32'hc5, 32'h80, RESP_OKAY);
        anEn <= 1'b1;
        for (int i = 0; i < 500 && linkUp !== 1'b1; i++) @(posedge clock);
        busRead(ADDR_STATUS, 32'hc5, 32'hc5, RESP_OKAY);
        link10 <= 1'b1;
        repeat (3) @(posedge clock);
        link10 <= 1'b0;
        for (int k = 0; k < 3; k++) sendFrame(4 + 3 * k, k == 1);
        // Lock lost right after the second preamble nibble must end the packet
        nibQ.push_back({1'b0, NIB_PREAMBLE});
        nibQ.push_back({1'b0, NIB_PREAMBLE});
        sendBits(CODE_J, 5);
        sendBits(CODE_K, 5);
        sendOnes(5);
        descLock <= 1'b0;
        sendOnes(2);
        check(32'(miiRx.valid), 32'h0);
        check(32'(nibQ.size()), 32'h0);
        sendOnes(15);
        descLock <= 1'b1;
        sendBits(5'h0a, 5);
        sendBits(5'h0a, 5);
        sendOnes(30);
        check(32'(badSeen != 0), 32'h1);
        check(32'(carrierSense), 32'h0);
        for (int m = 0; m < 2; m++) begin
            startTx <= 1'b1;
            @(posedge clock);
            startTx <= 1'b0;
            repeat (4) @(posedge clock);
            check(32'(carrierSense), 32'(m == 0));
            busWrite(ADDR_CONTROL, 32'h0b);
        end
        busWrite(ADDR_CONTROL, 32'h19);
        anEn <= 1'b0;
        sigDet <= 1'b0;
        for (int i = 0; i < 200 && faultIdleActive !== 1'b1; i++) @(posedge clock);
        check(32'({faultIdleActive, txAllowed}), 32'h2);
        repeat (200) @(posedge clock);
        sigDet <= 1'b1;
        for (int i = 0; i < 500 && linkUp !== 1'b1; i++) @(posedge clock);
        repeat (3) @(posedge clock);
        check(32'({linkUp, faultIdleActive}), 32'h2);
        sendOnes(20);
        sendBits(5'h00, 1);
        repeat (3) begin
            sendOnes(84);
            sendBits(5'h00, 1);
        end
        sendOnes(6);
        check(32'(txAllowed), 32'h0);
        // A short run ends the fault; the status bit must still hold until read
        sendOnes(5);
        sendBits(5'h00, 1);
        sendOnes(100);
        busRead(ADDR_STATUS, 32'h10, 32'h10, RESP_OKAY);
        busRead(ADDR_STATUS, 32'h10, 32'h0, RESP_OKAY);
        check(32'(nibbleCount), 32'd32);
        wrap_up();
    end
endmodule
